// ==== logic/tpm_pkg.sv ====
// Constants shared by the twisted-pair attachment unit control logic
package tpm_pkg;
  // ******************************************************************
  // Clock and time base
  // ******************************************************************
  localparam int CLK_MHZ = 100;
  localparam int HALF_BIT_NS = 50;
  localparam int IDLE_NS = 200;
  localparam int LP_WIDTH_NS = 100;
  localparam int LP_MAX_NS = 400;
  localparam int SQE_DELAY_NS = 1100;
  localparam int SQE_LEN_NS = 1000;
  localparam int WIN_OPEN_US = 6500;
  localparam int WIN_CLOSE_US = 104000;
  localparam int LP_PERIOD_US = 16000;
  localparam int JAB_US = 50000;
  localparam int UNJAB_US = 500000;
  // Cycle counts; least times round up, longest times round down
  localparam int HALF_BIT_CYC = (HALF_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC = (IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int LP_WIDTH_CYC = (LP_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int LP_MAX_CYC = (LP_MAX_NS * CLK_MHZ) / 1000;
  localparam int SQE_DELAY_CYC = (SQE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int SQE_LEN_CYC = (SQE_LEN_NS * CLK_MHZ + 999) / 1000;
  localparam int WIN_OPEN_CYC = WIN_OPEN_US * CLK_MHZ;
  localparam int WIN_CLOSE_CYC = WIN_CLOSE_US * CLK_MHZ;
  localparam int LP_PERIOD_CYC = LP_PERIOD_US * CLK_MHZ;
  localparam int JAB_CYC = JAB_US * CLK_MHZ;
  localparam int UNJAB_CYC = UNJAB_US * CLK_MHZ;
  localparam int TMR_W = 27;
  localparam int STRAP_WAIT = 3;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_OVR_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // ******************************************************************
  // Operating modes and decoded settings
  // ******************************************************************
  localparam logic [2:0] MODE_PD = 3'h0;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_EXT_HB = 3'h3;
  localparam logic [2:0] MODE_LI_IN = 3'h5;
  localparam logic [2:0] MODE_LI_OUT = 3'h6;

  typedef struct packed {
    logic pd;
    logic hb;
    logic ext;
    logic li_forced;
    logic li_out;
    logic ap_forced;
    logic ap_val;
  } tpm_cfg_s;

  typedef enum logic [1:0] {LK_FAIL, LK_WAIT, LK_PASS} tpm_link_e;
endpackage

// ==== logic/tpm_dly_if.sv ====
// Carrier between the control core and its half-bit delay line
`timescale 1ns/10ps
interface tpm_dly_if;
  logic [1:0] din;
  logic [1:0] dout;
  modport src (output din, input dout);
  modport dly (input din, output dout);
endinterface

// ==== logic/tpm_delay.sv ====
// Registered delay line giving the half-bit lag for predistortion
`timescale 1ns/10ps
module tpm_delay
  import tpm_pkg::*;
#(
  parameter int DEPTH = HALF_BIT_CYC
)
(
  input wire logic mclk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  tpm_dly_if.dly bus // Data in, delayed data out
);
  logic [1:0] stage_reg [DEPTH];

  // ******************************************************************
  // Shift chain; last stage is the registered output
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < DEPTH; i++)
        stage_reg[i] <= 2'h0;
    end
    else
    begin
      stage_reg[0] <= bus.din;
      for (int i = 1; i < DEPTH; i++)
        stage_reg[i] <= stage_reg[i - 1];
    end
  end

  assign bus.dout = stage_reg[DEPTH - 1];
endmodule

// ==== logic/tpm_link_ctl.sv ====
// Control core of the twisted-pair attachment unit
//
// Overview of operation
// - Collision LED is off normally and lit while a collision is seen.
// - Receive LED on by default; without link check, off while receiving.
// - With link check on, receive LED stays off while link is failed.
// - Transmit LED on by default, off while transmitting onto the pair.
// - Predistortion pair carries main output inverted, half a bit late; here link pulses leave it low.
// - AUI transmit data is forwarded to the twisted-pair drivers.
// - Twisted-pair receive data is forwarded to the AUI receive pair.
// - Simultaneous transmit and receive drives 10 MHz onto collision pair.
// - With link check on, link pulses are sent while no data is sent; here any DTE activity stops them, even when jabbered or link failed.
// - Incoming link pulses are recognised and bring the link up.
// - Link pin used as output enables link check and shows link state.
// - Heartbeat on: send SQE test to DTE after each good transmission.
// - Line length select: standard or lowered squelch thresholds.
// - Auto-polarity on and pair reversed: received data is inverted.
// - A polarity status output can drive a reversed-pair indicator.
// - Power-down mode shuts every function off.
// - AUI outputs go high impedance while the link is not connected.
// - Mode 5: link check on, auto-polarity off, link pin is input.
// - Mode 6: link check and auto-polarity on, link pin is output.
// - Open mode select inputs read as logic high.
// - Jabber LED off normally, on once watchdog expired, driver off.
// - Link pin as output: low when link failed, high when passed.
// - Auto-polarity is enabled whenever its pin is sampled high; modes 5 and 6 ignore the pin (5 forces it off, 6 on).
// - Internal timing is derived from the 20 MHz crystal reference; here every timer counts mclk and the crystal only paces the collision wave.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module tpm_link_ctl
  import tpm_pkg::*;
#(
  parameter int OPEN_CYC = WIN_OPEN_CYC,
  parameter int CLOSE_CYC = WIN_CLOSE_CYC,
  parameter int LPER_CYC = LP_PERIOD_CYC,
  parameter int JABT_CYC = JAB_CYC,
  parameter int UNJ_CYC = UNJAB_CYC
)
(
  input wire logic mclk, // 100 MHz system clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic crystal_ref_in, // 20 MHz crystal reference
  input wire logic opmode_sel_0, // Mode select bit 0
  input wire logic opmode_sel_1, // Mode select bit 1
  input wire logic opmode_sel_2, // Mode select bit 2
  input wire logic aui_do, // AUI transmit data level
  input wire logic tp_in_pos, // Receive pair, positive comparator
  input wire logic tp_in_neg, // Receive pair, negative comparator
  output logic tp_out_pos, // Twisted-pair driver, positive
  output logic tp_out_neg, // Twisted-pair driver, negative
  output logic tp_predist_pos, // Predistortion driver, positive
  output logic tp_predist_neg, // Predistortion driver, negative
  output logic aui_di, // AUI receive data
  output logic aui_di_oe_b, // AUI receive pair enable, low drives
  output logic aui_ci, // AUI collision signal
  output logic aui_ci_oe_b, // AUI collision pair enable, low drives
  input wire logic link_check_pin_i, // Link pin level in
  output logic link_check_pin_o, // Link pin level out
  output logic link_check_pin_oe_b, // Link pin enable, low drives
  input wire logic polarity_fix_pin_i, // Auto-polarity pin level in
  output logic polarity_fix_pin_o, // Auto-polarity pin level out
  output logic polarity_fix_pin_oe_b, // Auto-polarity pin enable
  output logic squelch_low, // Lowered squelch thresholds
  output logic collision_led, // Collision LED, 1 lit
  output logic receive_led, // Receive LED, 1 lit
  output logic transmit_led, // Transmit LED, 1 lit
  output logic jabber_led // Jabber LED, 1 lit
);
  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [1:0] xt_s, do_s, ip_s, in_s, li_s, ap_s;
  logic [2:0] md_s0, md_s1;
  logic xt_d, do_d, rp_d, rn_d, ci_sq;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic [2:0] mode_strap;
  logic li_pin_low, ap_pin_high;
  logic [4:0] ctrl_reg;
  tpm_cfg_s cfg;
  logic li_en, ap_en, pd;
  logic [7:0] tx_idle, rx_idle;
  logic tx_act, rx_act, rx_act_d, tx_act_d, tx_good;
  logic [TMR_W-1:0] rx_len, lk_tmr, lp_tmr, jab_tmr;
  tpm_link_e link_state;
  logic have_prev, link_ok, rx_pulse, rx_frame, pulse_neg, rev;
  logic jab, tx_drive, lp_on, coll, sqe_on;
  logic [7:0] lp_w;
  logic [11:0] sqe_cnt;
  logic tp_d, tp_v, ci_on;
  tpm_dly_if dif ();

  // Decode the mode straps; 7 is what open pins give
  function automatic tpm_cfg_s dec_mode(input logic [2:0] m);
    tpm_cfg_s c;
    c = '0;
    c.pd = (m == MODE_PD);
    c.hb = m[0];
    c.ext = (m == MODE_EXT) || (m == MODE_EXT_HB);
    c.li_forced = (m == MODE_LI_IN) || (m == MODE_LI_OUT);
    c.li_out = (m == MODE_LI_OUT);
    c.ap_forced = c.li_forced;
    c.ap_val = (m == MODE_LI_OUT);
    return c;
  endfunction

  // Level changes seen within the idle window mean activity
  function automatic logic [7:0] idle_next(input logic edge_seen,
                                           input logic [7:0] cnt);
    if (edge_seen)
      return 8'h00;
    else if (cnt < 8'(IDLE_CYC))
      return cnt + 8'h01;
    else
      return cnt;
  endfunction

  // ******************************************************************
  // Pin synchronisers; first stage feeds only the second
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    xt_s <= {xt_s[0], crystal_ref_in};
    do_s <= {do_s[0], aui_do};
    ip_s <= {ip_s[0], tp_in_pos};
    in_s <= {in_s[0], tp_in_neg};
    li_s <= {li_s[0], link_check_pin_i};
    ap_s <= {ap_s[0], polarity_fix_pin_i};
    md_s0 <= {opmode_sel_2, opmode_sel_1, opmode_sel_0};
    md_s1 <= md_s0;
  end

  // Edge history of synchronised levels
  always_ff @(posedge mclk)
  begin
    xt_d <= xt_s[1];
    do_d <= do_s[1];
    rp_d <= ip_s[1];
    rn_d <= in_s[1];
  end

  // ******************************************************************
  // Strap capture after reset release; the pins may be driven later
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      mode_strap <= 3'h7;
      li_pin_low <= 1'b0;
      ap_pin_high <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'(STRAP_WAIT))
      begin
        strap_done <= 1'b1;
        mode_strap <= md_s1;
        li_pin_low <= !li_s[1];
        ap_pin_high <= ap_s[1];
      end
    end
  end

  // Settings: straps unless software overrides the mode
  always_comb
  begin
    cfg = dec_mode(ctrl_reg[CTRL_OVR_BIT] ?
                   ctrl_reg[CTRL_MODE_LSB +: 3] : mode_strap);
    pd = cfg.pd || ctrl_reg[CTRL_PD_BIT] || !strap_done;
    li_en = cfg.li_forced || cfg.li_out || li_pin_low;
    ap_en = cfg.ap_forced ? cfg.ap_val : ap_pin_high;
  end

  // ******************************************************************
  // Wishbone slave: one wait state, unmapped reads give zero
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= CTRL_RST;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS)
          ctrl_reg <= wb_dat_i[4:0];
        if (!wb_we_i && wb_adr_i == CTRL_OFS)
          wb_dat_o <= {27'h0, ctrl_reg};
        if (!wb_we_i && wb_adr_i == STAT_OFS)
          wb_dat_o <= {20'h0, mode_strap, pd, rx_act, tx_act,
                       coll, jab, rev, link_ok, link_state};
      end
    end
  end

  // ******************************************************************
  // Activity detection on both inputs
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      tx_idle <= 8'(IDLE_CYC);
      rx_idle <= 8'(IDLE_CYC);
      tx_act_d <= 1'b0;
      rx_act_d <= 1'b0;
    end
    else
    begin
      tx_idle <= idle_next(do_s[1] != do_d, tx_idle);
      rx_idle <= idle_next((ip_s[1] != rp_d) || (in_s[1] != rn_d), rx_idle);
      tx_act_d <= tx_act;
      rx_act_d <= rx_act;
    end
  end

  assign tx_act = tx_idle < 8'(IDLE_CYC);
  assign rx_act = rx_idle < 8'(IDLE_CYC);

  // Burst length sorts link pulses from frames; polarity from first line
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      rx_len <= '0;
      pulse_neg <= 1'b0;
    end
    else if (!rx_act)
    begin
      rx_len <= '0;
      if (in_s[1] && !ip_s[1])
        pulse_neg <= 1'b1;
      else if (ip_s[1])
        pulse_neg <= 1'b0;
    end
    else if (rx_len < TMR_W'(LP_MAX_CYC))
      rx_len <= rx_len + 1'b1;
  end

  assign rx_pulse = rx_act_d && !rx_act && rx_len < TMR_W'(LP_MAX_CYC);
  assign rx_frame = rx_act_d && !rx_act && !rx_pulse;

  // A negative link pulse marks the pair as reversed
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
      rev <= 1'b0;
    else if (rx_pulse)
      rev <= pulse_neg;
  end

  // ******************************************************************
  // Link integrity state machine
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd || !li_en)
    begin
      link_state <= LK_FAIL;
      lk_tmr <= '0;
      have_prev <= 1'b0;
    end
    else
    begin
      if (lk_tmr < TMR_W'(CLOSE_CYC))
        lk_tmr <= lk_tmr + 1'b1;
      case (link_state)
        LK_PASS:
        begin
          if (rx_frame || rx_act || (rx_pulse && lk_tmr >= TMR_W'(OPEN_CYC)))
            lk_tmr <= '0;
          else if (lk_tmr >= TMR_W'(CLOSE_CYC))
            link_state <= LK_FAIL;
        end
        LK_FAIL:
        begin
          if (rx_frame)
            link_state <= LK_WAIT;
          else if (rx_pulse)
          begin
            if (have_prev && lk_tmr >= TMR_W'(OPEN_CYC) &&
                lk_tmr < TMR_W'(CLOSE_CYC))
              link_state <= LK_WAIT;
            have_prev <= 1'b1;
            lk_tmr <= '0;
          end
          else if (lk_tmr >= TMR_W'(CLOSE_CYC))
            have_prev <= 1'b0;
        end
        LK_WAIT:
        begin
          lk_tmr <= '0;
          have_prev <= 1'b0;
          if (!tx_act && !rx_act)
            link_state <= LK_PASS;
        end
        default:
          link_state <= LK_FAIL;
      endcase
    end
  end

  assign link_ok = !pd && (!li_en || link_state == LK_PASS);

  // ******************************************************************
  // Jabber watchdog: cuts the driver, holds until quiet long enough
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      jab <= 1'b0;
      jab_tmr <= '0;
    end
    else if (!jab)
    begin
      jab_tmr <= tx_act ? jab_tmr + 1'b1 : '0;
      if (tx_act && jab_tmr >= TMR_W'(JABT_CYC - 1))
      begin
        jab <= 1'b1;
        jab_tmr <= '0;
      end
    end
    else
    begin
      jab_tmr <= tx_act ? '0 : jab_tmr + 1'b1;
      if (!tx_act && jab_tmr >= TMR_W'(UNJ_CYC - 1))
        jab <= 1'b0;
    end
  end

  assign tx_drive = tx_act && link_ok && !jab;

  // ******************************************************************
  // Outgoing link pulses while the DTE is quiet, also when jabbered or link failed
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd || !li_en || tx_act)
    begin
      lp_tmr <= '0;
      lp_w <= 8'h00;
    end
    else if (lp_tmr >= TMR_W'(LPER_CYC - 1))
    begin
      lp_tmr <= '0;
      lp_w <= 8'(LP_WIDTH_CYC);
    end
    else
    begin
      lp_tmr <= lp_tmr + 1'b1;
      if (lp_w != 8'h00)
        lp_w <= lp_w - 8'h01;
    end
  end

  assign lp_on = lp_w != 8'h00;

  // ******************************************************************
  // SQE test after a good transmission, then collision pair logic
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      tx_good <= 1'b0;
      sqe_cnt <= 12'h000;
    end
    else
    begin
      if (tx_act && !tx_act_d)
        tx_good <= 1'b1;
      else if (jab || !link_ok)
        tx_good <= 1'b0;
      if (tx_act_d && !tx_act && tx_good && cfg.hb)
        sqe_cnt <= 12'(SQE_DELAY_CYC + SQE_LEN_CYC);
      else if (sqe_cnt != 12'h000)
        sqe_cnt <= sqe_cnt - 12'h001;
    end
  end

  assign sqe_on = sqe_cnt != 12'h000 && sqe_cnt <= 12'(SQE_LEN_CYC);
  assign coll = tx_act && rx_act && link_ok;
  assign ci_on = coll || jab || sqe_on;

  // 10 MHz square wave: toggle on each crystal rising edge
  always_ff @(posedge mclk)
  begin
    if (!rst_b || !ci_on)
      ci_sq <= 1'b0;
    else if (xt_s[1] && !xt_d)
      ci_sq <= !ci_sq;
  end

  // ******************************************************************
  // Transmit data path and predistortion delay
  // ******************************************************************
  assign tp_d = tx_drive ? do_s[1] : lp_on;
  assign tp_v = tx_drive;
  assign dif.din = {tp_v, tp_d};

  tpm_delay u_delay (
    .mclk (mclk),
    .rst_b (rst_b),
    .bus (dif.dly)
  );

  // ******************************************************************
  // Output registers; every pin comes straight from a flop
  // ******************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      tp_out_pos <= 1'b0;
      tp_out_neg <= 1'b0;
      tp_predist_pos <= 1'b0;
      tp_predist_neg <= 1'b0;
    end
    else
    begin
      // Idle drives both lines low; pulses only use the positive line
      tp_out_pos <= tp_d;
      tp_out_neg <= tp_v && !tp_d;
      tp_predist_pos <= dif.dout[1] && !dif.dout[0];
      tp_predist_neg <= dif.dout[1] && dif.dout[0];
    end
  end

  // AUI side; receive data wins over loopback of transmit data
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      aui_di <= 1'b0;
      aui_di_oe_b <= 1'b1;
      aui_ci <= 1'b0;
      aui_ci_oe_b <= 1'b1;
    end
    else
    begin
      if (rx_act)
        aui_di <= ip_s[1] ^ (ap_en && rev);
      else
        aui_di <= tx_drive && do_s[1];
      aui_di_oe_b <= !link_ok;
      aui_ci <= ci_sq;
      aui_ci_oe_b <= !link_ok;
    end
  end

  // LEDs and strap pins
  always_ff @(posedge mclk)
  begin
    if (!rst_b || pd)
    begin
      collision_led <= 1'b0;
      receive_led <= 1'b0;
      transmit_led <= 1'b0;
      jabber_led <= 1'b0;
      squelch_low <= 1'b0;
      link_check_pin_o <= 1'b0;
      link_check_pin_oe_b <= 1'b1;
      polarity_fix_pin_o <= 1'b0;
      polarity_fix_pin_oe_b <= 1'b1;
    end
    else
    begin
      collision_led <= coll;
      if (li_en)
        receive_led <= link_ok;
      else
        receive_led <= !rx_act;
      transmit_led <= !tx_drive;
      jabber_led <= jab;
      squelch_low <= cfg.ext;
      link_check_pin_o <= link_state == LK_PASS;
      link_check_pin_oe_b <= !cfg.li_out;
      // Sinks the indicator low while reversed with auto-polarity on; released otherwise
      polarity_fix_pin_o <= 1'b0;
      polarity_fix_pin_oe_b <= !(ap_en && rev);
    end
  end
endmodule

// ==== testbench/tpm_link_ctl_monitor.sv ====
// Port checker for the attachment unit control core
`timescale 1ns/10ps
module tpm_link_ctl_monitor
(
  input wire logic mclk, // Clock
  input wire logic rst_b, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic opmode_sel_0, // Strap 0
  input wire logic opmode_sel_1, // Strap 1
  input wire logic opmode_sel_2, // Strap 2
  input wire logic aui_do, // DTE data
  input wire logic tp_out_pos, // Driver
  input wire logic tp_predist_pos, // Predistortion
  input wire logic aui_di_oe_b, // DI enable
  input wire logic aui_ci_oe_b, // CI enable
  input wire logic aui_ci, // CI wave
  input wire logic link_check_pin_o, // Link level
  input wire logic link_check_pin_oe_b, // Link enable
  input wire logic receive_led, // Rx LED
  input wire logic transmit_led, // Tx LED
  input wire logic collision_led, // Col LED
  input wire logic jabber_led // Jab LED
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ****
  // Properties
  // ****
  // Three cycles of failed link on the pin; pin and LED registers load on the same edge
  sequence li_fail;
    (!link_check_pin_oe_b && !link_check_pin_o) [*3];
  endsequence
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  pred_inv_a: assert property (
    $rose(tp_out_pos) |-> ##5 !tp_predist_pos) else $error("predist");
  tx_fwd_a: assert property (
    $rose(aui_do) && !aui_di_oe_b && !jabber_led
    |-> ##[2:4] (tp_out_pos || jabber_led))
    else $error("tx data");
  tx_led_a: assert property (
    tp_out_pos ##5 !tp_out_pos ##5 tp_out_pos |-> !transmit_led)
    else $error("tx led");
  rx_fail_a: assert property (
    li_fail |-> !receive_led) else $error("rx led on");
  aui_hiz_a: assert property (
    li_fail |-> aui_di_oe_b && aui_ci_oe_b) else $error("aui driven");
  col_ci_a: assert property (
    $rose(collision_led) |-> ##[1:40] aui_ci) else $error("no ci");
  pd_off_a: assert property (
    (!opmode_sel_0 && !opmode_sel_1 && !opmode_sel_2) [*8]
    |-> !receive_led && !transmit_led && !tp_out_pos) else $error("pd");
  cover property (collision_led);
  cover property (li_fail ##1 link_check_pin_o);
  cover property (!aui_ci_oe_b && transmit_led);
endmodule

bind tpm_link_ctl tpm_link_ctl_monitor u_mon (.*);

// ==== testbench/tpm_far_end.sv ====
// Far side model: DTE transmit data and twisted-pair partner
`timescale 1ns/10ps
module tpm_far_end
(
  input wire logic mclk, // Clock
  output logic tp_in_pos, // Pair, positive
  output logic tp_in_neg, // Pair, negative
  output logic aui_do // DTE data
);
  // Idle pair is low on both lines
  initial
  begin
    {tp_in_pos, tp_in_neg, aui_do} = 3'h0;
  end
  // DTE data, one edge every half bit
  task tx(input int n);
    repeat (n)
    begin
      repeat (5) @(posedge mclk);
      aui_do <= ~aui_do;
    end
    @(posedge mclk);
    aui_do <= 1'h0;
  endtask
  // Receive frame, lines complementary
  task frame(input int n);
    repeat (n)
    begin
      repeat (5) @(posedge mclk);
      tp_in_pos <= ~tp_in_pos;
      tp_in_neg <= tp_in_pos;
    end
    @(posedge mclk);
    {tp_in_pos, tp_in_neg} <= 2'h0;
  endtask
  // Link pulse; rev puts it on the wrong line
  task pulse(input logic rev);
    @(posedge mclk);
    if (rev)
      tp_in_neg <= 1'h1;
    else
      tp_in_pos <= 1'h1;
    repeat (10) @(posedge mclk);
    {tp_in_pos, tp_in_neg} <= 2'h0;
  endtask
endmodule

// ==== testbench/tpm_link_ctl_tb_top.sv ====
// Self-checking bench for the attachment unit control core
`timescale 1ns/10ps
module tpm_link_ctl_tb_top;
  import tpm_pkg::*;
  logic mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic crystal_ref_in, aui_do, tp_in_pos, tp_in_neg, tp_out_pos;
  logic tp_out_neg, tp_predist_pos, tp_predist_neg, aui_di, aui_ci;
  logic aui_di_oe_b, aui_ci_oe_b, link_check_pin_o, link_check_pin_oe_b;
  logic polarity_fix_pin_o, polarity_fix_pin_oe_b, squelch_low;
  logic collision_led, receive_led, transmit_led, jabber_led;
  logic li_lvl, ap_lvl;
  logic [2:0] mode;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int fails = 0, n_tests = 0, cyc_n = 0;
  // Pad level: pin driven low-enable, else the bench strap
  wire link_check_pin_i = link_check_pin_oe_b ? li_lvl : link_check_pin_o;
  wire polarity_fix_pin_i =
    polarity_fix_pin_oe_b ? ap_lvl : polarity_fix_pin_o;
  // Short link windows keep the run brief
  tpm_link_ctl #(.OPEN_CYC(200), .CLOSE_CYC(2000), .LPER_CYC(500),
    .JABT_CYC(3000), .UNJ_CYC(400)) u_dut (.*, .opmode_sel_0(mode[0]),
    .opmode_sel_1(mode[1]), .opmode_sel_2(mode[2]));
  tpm_far_end u_far (.*);
  // Clocks; crystal free running, phase unrelated
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    crystal_ref_in = 0;
    #3;
    forever #80 crystal_ref_in = ~crystal_ref_in;
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000)
    begin
      fails++;
      give_verdict;
    end
  end
  task chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'h1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // Straps only count at reset, so each mode needs one
  task rst(input logic [2:0] m, input logic li);
    @(posedge mclk);
    rst_b <= 1'h0;
    mode <= m;
    li_lvl <= li;
    ap_lvl <= li;
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (10) @(posedge mclk);
  endtask
  // One classic cycle; read data lands in rd
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= {4{!d[31]}}; // Bit 31 set: no lanes, write dropped
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task t_modes;
    rst(3'h0, 1'h1);
    chk(!receive_led && !transmit_led && !tp_out_pos, "pd");
    rst(3'h2, 1'h1);
    chk(squelch_low === 1'h1, "long line");
    rst(3'h1, 1'h1);
    chk(squelch_low === 1'h0, "short line");
    chk(receive_led && transmit_led && !collision_led, "idle");
    wb(1'h1, CTRL_OFS, 32'h1);
    repeat (4) @(posedge mclk);
    chk(!receive_led && !transmit_led, "soft pd");
    wb(1'h1, CTRL_OFS, 32'h0);
    wb(1'h0, 4'h8, 32'h0);
    chk(rd === 32'h0, "unmapped");
    wb(1'h1, CTRL_OFS, 32'h8000_0001);
    wb(1'h0, STAT_OFS, 32'h0);
    chk(rd[11:8] === 4'h2, "strap");
    $display("modes done");
  endtask
  task t_traffic;
    logic p;
    int k;
    fork
      u_far.tx(40);
      begin
        repeat (25) @(posedge mclk);
        chk(transmit_led === 1'h0, "tx led");
      end
    join
    k = 0;
    while (aui_ci !== 1'h1 && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    chk(k > 50 && k < 300, "sqe");
    repeat (300) @(posedge mclk);
    fork
      u_far.frame(40);
      begin
        repeat (27) @(posedge mclk);
        p = tp_in_pos;
        chk(receive_led === 1'h0, "rx led");
        repeat (3) @(posedge mclk);
        chk(aui_di === p && !aui_di_oe_b, "rx data");
      end
    join
    repeat (300) @(posedge mclk);
    fork
      u_far.tx(60);
      u_far.frame(60);
      begin
        repeat (40) @(posedge mclk);
        p = aui_ci;
        chk(collision_led === 1'h1, "col led");
        repeat (16) @(posedge mclk);
        chk(aui_ci !== p && !aui_ci_oe_b, "ci wave");
      end
    join
    repeat (400) @(posedge mclk);
    u_far.tx(640);
    chk(jabber_led === 1'h1, "jabber");
    $display("traffic done");
  endtask
  task t_link;
    int k;
    rst(3'h5, 1'h1);
    chk(link_check_pin_oe_b && !receive_led, "mode 5");
    rst(3'h6, 1'h1);
    chk(!link_check_pin_oe_b && !link_check_pin_o, "fail");
    chk(!receive_led && aui_di_oe_b, "fail quiet");
    k = 0;
    while (tp_out_pos !== 1'h1 && k < 700)
    begin
      @(posedge mclk);
      k++;
    end
    chk(k < 700, "pulse out");
    u_far.pulse(1'h1);
    repeat (300) @(posedge mclk);
    u_far.pulse(1'h1);
    repeat (100) @(posedge mclk);
    chk(link_check_pin_o === 1'h1, "pass");
    chk(polarity_fix_pin_oe_b === 1'h0, "reversed");
    wb(1'h0, STAT_OFS, 32'h0);
    chk(rd[1:0] === 2'h2 && rd[3] === 1'h1, "status");
    rst(3'h7, 1'h0);
    chk(!receive_led && link_check_pin_oe_b, "pin li");
    $display("link done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, ap_lvl} = 5'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
    mode = 3'h1;
    li_lvl = 1'h1;
    t_modes;
    t_traffic;
    t_link;
    give_verdict;
  end
endmodule
